/* core/hdo_consts.svh */
//--------------------------------------------------------------------
// Purpose: offsets, field positions, codes and times of the output
//          conditioning block
// Assumes: 25 MHz core clock
// Notes:   times are given in ns; cycle counts are derived in the core
//--------------------------------------------------------------------
`ifndef HDO_CONSTS_SVH
`define HDO_CONSTS_SVH

// ------------------------------------------------------------
// signal path configuration word fields
// ------------------------------------------------------------
`define HDO_RANGE_EXT_BIT 9
`define HDO_FMT_HI        7
`define HDO_FMT_LO        5
`define HDO_FILT_HI       4
`define HDO_FILT_LO       3
`define HDO_RNG_HI        2
`define HDO_RNG_LO        1

// ------------------------------------------------------------
// output format codes
// ------------------------------------------------------------
`define HDO_FMT_ANALOG    3'h0
`define HDO_FMT_MUX_CONT  3'h1
`define HDO_FMT_MUX_TRIG  3'h3
`define HDO_FMT_BURN      3'h2
`define HDO_FMT_PWM       3'h6
`define HDO_FMT_PWM_INV   3'h7

// ------------------------------------------------------------
// range codes {extension, select} and filter codes
// ------------------------------------------------------------
`define HDO_RNG_15        3'h4
`define HDO_RNG_30        3'h0
`define HDO_RNG_60        3'h1
`define HDO_RNG_80        3'h2
`define HDO_RNG_100       3'h3
`define HDO_RNG_150       3'h7
`define HDO_FILT_80       2'h0
`define HDO_FILT_500      2'h2
`define HDO_FILT_1K       2'h3
`define HDO_FILT_2K       2'h1

// ------------------------------------------------------------
// arithmetic
// ------------------------------------------------------------
`define HDO_RESULT_MAX    14'h3fff
`define HDO_GAIN_FRAC     11
`define HDO_SAW_STEP      14'h0010
`define HDO_TC_GROUP_DEF  2'h1

// ------------------------------------------------------------
// timing in ns, and the pwm step count
// ------------------------------------------------------------
`define HDO_CLK_PERIOD_NS   32'h0000_0028
`define HDO_PWM_PERIOD_NS   32'h007a_1200
`define HDO_MUX_SLOT_NS     32'h000f_4240
`define HDO_TRIG_REFRESH_NS 32'h001e_8480
`define HDO_PWM_STEPS       32'h0000_0800

`endif

/* core/hdo_pkg.sv */
//--------------------------------------------------------------------
// Purpose: types shared by the output conditioning block
// Assumes: nothing
// Notes:   configuration words arrive from nonvolatile storage
//--------------------------------------------------------------------
package hdo_pkg;

	typedef enum logic [2:0] {
		FMT_ANALOG,
		FMT_MUX_CONT,
		FMT_MUX_TRIG,
		FMT_BURN,
		FMT_PWM,
		FMT_PWM_INV
	} hdo_fmt_type;

	typedef enum logic [2:0] {
		RNG_15MT,
		RNG_30MT,
		RNG_60MT,
		RNG_80MT,
		RNG_100MT,
		RNG_150MT
	} hdo_range_type;

	typedef enum logic [1:0] {
		FILT_80HZ,
		FILT_500HZ,
		FILT_1KHZ,
		FILT_2KHZ
	} hdo_filter_type;

	typedef struct packed {
		logic        lock;
		logic [8:0]  clamp_high;
		logic [7:0]  clamp_low;
		logic [10:0] offset;
		logic [13:0] gain;
		logic [1:0]  tc_group;
		logic [2:0]  quadratic_temp_coeff;
		logic [4:0]  linear_temp_coeff;
		logic [9:0]  signal_path_config;
	} hdo_nvcfg_type;

	typedef struct packed {
		hdo_range_type  range;
		hdo_filter_type filter;
		logic [1:0]     temp_coeff_group;
		logic [4:0]     linear_temp_coeff;
		logic [2:0]     quadratic_temp_coeff;
	} hdo_conv_ctrl_type;

endpackage

/* core/hdo_core.sv */
//--------------------------------------------------------------------
// Purpose: gain, offset and clamp of the filtered field value, and the
//          analog, multiplexed, burn-in and pulse-width output formats
// Assumes: filtered samples arrive on the core clock; load sense is a
//          pin and is synchronised here
// Notes:   configuration words are sampled every clock, except the lock, caught once after reset release
//--------------------------------------------------------------------
`include "hdo_consts.svh"

module hdo_core
	import hdo_pkg::*;
#(
	parameter bit          REDUCED          = 1'b0,
	parameter int unsigned PWM_PERIOD_CYC   =
		`HDO_PWM_PERIOD_NS / `HDO_CLK_PERIOD_NS,
	parameter int unsigned MUX_SLOT_CYC     =
		`HDO_MUX_SLOT_NS / `HDO_CLK_PERIOD_NS,
	parameter int unsigned TRIG_REFRESH_CYC =
		`HDO_TRIG_REFRESH_NS / `HDO_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// nonvolatile configuration
	input  wire hdo_nvcfg_type     nv_cfg,
	// filtered converter samples
	input  wire logic [13:0]       field_sample,
	input  wire logic              sample_valid,
	// output pin load sense
	input  wire logic              load_sense_in,
	// converter control
	output hdo_conv_ctrl_type      conv_ctrl_ff,
	// programming side
	output logic [13:0]            readout_ff,
	output logic                   prog_enable_ff,
	// output stage
	output logic [11:0]            dac_code_ff,
	output logic                   dac_en_ff,
	output logic                   pwm_out_ff,
	output logic                   pwm_oe_n_ff
);

	// ------------------------------------------------------------
	// derived counts
	// ------------------------------------------------------------
	localparam int unsigned TICK_RAW = PWM_PERIOD_CYC / `HDO_PWM_STEPS;
	localparam int unsigned TICK_CYC = (TICK_RAW < 1) ? 1 : TICK_RAW;
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);
	localparam logic [31:0] SLOT_LAST = 32'(MUX_SLOT_CYC - 1);
	localparam logic [31:0] REFR_LAST = 32'(TRIG_REFRESH_CYC - 1);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	hdo_fmt_type        fmt_ff;
	hdo_fmt_type        nxt_fmt;
	hdo_conv_ctrl_type  nxt_conv;
	logic               lock_active_ff;
	logic               lock_seen_ff;
	logic               load_sync1_ff;
	logic               load_sync2_ff;
	logic [13:0]        saw_ff;
	logic signed [27:0] prod_ff;
	logic               v1_ff;
	logic [13:0]        result_ff;
	logic signed [17:0] sum_w;
	logic signed [16:0] term_w;
	logic [13:0]        sat_w;
	logic [13:0]        clamp_lo_w;
	logic [13:0]        clamp_hi_w;
	logic [13:0]        nxt_result;
	logic [13:0]        rev_w;
	logic [31:0]        mux_tmr_ff;
	logic               mux_half_ff;
	logic [13:0]        mux_snap_ff;
	logic [31:0]        pwm_tick_ff;
	logic [10:0]        pwm_cnt_ff;
	logic [10:0]        duty_ff;
	logic [10:0]        nxt_duty;
	logic               period_start_w;
	logic               is_mux_w;
	logic               is_pwm_w;
	logic               mux_zero_w;

	// ------------------------------------------------------------
	// configuration decode
	// ------------------------------------------------------------
	always_comb begin
		case (nv_cfg.signal_path_config[`HDO_FMT_HI:`HDO_FMT_LO])
			`HDO_FMT_ANALOG:   nxt_fmt = FMT_ANALOG;
			`HDO_FMT_MUX_CONT: nxt_fmt = FMT_MUX_CONT;
			`HDO_FMT_MUX_TRIG: nxt_fmt = FMT_MUX_TRIG;
			`HDO_FMT_BURN:     nxt_fmt = FMT_BURN;
			`HDO_FMT_PWM:      nxt_fmt = FMT_PWM;
			`HDO_FMT_PWM_INV:  nxt_fmt = FMT_PWM_INV;
			default:           nxt_fmt = FMT_ANALOG;
		endcase
		if (REDUCED) begin
			nxt_fmt = FMT_ANALOG;
		end
	end

	always_comb begin
		nxt_conv = '0;
		case ({nv_cfg.signal_path_config[`HDO_RANGE_EXT_BIT],
			nv_cfg.signal_path_config[`HDO_RNG_HI:`HDO_RNG_LO]})
			`HDO_RNG_15:  nxt_conv.range = REDUCED ? RNG_30MT : RNG_15MT;
			`HDO_RNG_30:  nxt_conv.range = RNG_30MT;
			`HDO_RNG_60:  nxt_conv.range = RNG_60MT;
			`HDO_RNG_80:  nxt_conv.range = RNG_80MT;
			`HDO_RNG_100: nxt_conv.range = RNG_100MT;
			`HDO_RNG_150: nxt_conv.range = RNG_150MT;
			default:      nxt_conv.range = RNG_30MT;
		endcase
		case (nv_cfg.signal_path_config[`HDO_FILT_HI:`HDO_FILT_LO])
			`HDO_FILT_80:  nxt_conv.filter = FILT_80HZ;
			`HDO_FILT_500: nxt_conv.filter = FILT_500HZ;
			`HDO_FILT_1K:  nxt_conv.filter = FILT_1KHZ;
			`HDO_FILT_2K:  nxt_conv.filter = FILT_2KHZ;
			default:       nxt_conv.filter = FILT_80HZ;
		endcase
		nxt_conv.linear_temp_coeff    = nv_cfg.linear_temp_coeff;
		nxt_conv.quadratic_temp_coeff = nv_cfg.quadratic_temp_coeff;
		nxt_conv.temp_coeff_group     = nv_cfg.tc_group;
		// unavailable groups fall back to the default group
		if (nxt_conv.range == RNG_15MT && !nv_cfg.tc_group[0]) begin
			nxt_conv.temp_coeff_group = `HDO_TC_GROUP_DEF;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fmt_ff       <= FMT_ANALOG;
			conv_ctrl_ff <= '0;
		end else begin
			fmt_ff       <= nxt_fmt;
			conv_ctrl_ff <= nxt_conv;
		end
	end

	// ------------------------------------------------------------
	// lock, caught once after reset release
	// ------------------------------------------------------------
	// a lock written during operation only bites after the next power-up
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lock_active_ff <= 1'b0;
			lock_seen_ff   <= 1'b0;
			prog_enable_ff <= 1'b0;
		end else begin
			if (!lock_seen_ff) begin
				lock_active_ff <= nv_cfg.lock;
				lock_seen_ff   <= 1'b1;
			end
			prog_enable_ff <= lock_seen_ff && !lock_active_ff;
		end
	end

	// ------------------------------------------------------------
	// load sense synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			load_sync1_ff <= 1'b0;
			load_sync2_ff <= 1'b0;
		end else begin
			load_sync1_ff <= load_sense_in;
			load_sync2_ff <= load_sync1_ff;
		end
	end

	// ------------------------------------------------------------
	// processing path
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			saw_ff <= '0;
		end else if (sample_valid && fmt_ff == FMT_BURN) begin
			saw_ff <= saw_ff + `HDO_SAW_STEP;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prod_ff <= '0;
			v1_ff   <= 1'b0;
		end else begin
			v1_ff <= sample_valid;
			if (sample_valid) begin
				// burn-in replaces the field, gain and clamps still apply
				prod_ff <= $signed(fmt_ff == FMT_BURN ? saw_ff
					: field_sample) * $signed(nv_cfg.gain);
			end
		end
	end

	// the field term spans at most one supply, so a negative offset
	// also lowers the top of the output range
	always_comb begin
		term_w = $signed(prod_ff[27:`HDO_GAIN_FRAC]);
		if (term_w > $signed({3'h0, `HDO_RESULT_MAX})) begin
			term_w = $signed({3'h0, `HDO_RESULT_MAX});
		end
	end

	// offset lsb is 16 result lsb, clamp lsb is 32 result lsb
	assign sum_w = 18'(term_w)
		+ 18'($signed({nv_cfg.offset, 4'h0}));
	assign clamp_lo_w = {1'b0, nv_cfg.clamp_low, 5'h00};
	assign clamp_hi_w = {nv_cfg.clamp_high, 5'h00};

	always_comb begin
		if (sum_w[17]) begin
			sat_w = '0;
		end else if (sum_w[16:14] != 3'h0) begin
			sat_w = `HDO_RESULT_MAX;
		end else begin
			sat_w = sum_w[13:0];
		end
		// upper clamp wins if the two limits cross
		nxt_result = sat_w;
		if (sat_w < clamp_lo_w) begin
			nxt_result = clamp_lo_w;
		end
		if (nxt_result > clamp_hi_w) begin
			nxt_result = clamp_hi_w;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_ff <= '0;
		end else if (v1_ff) begin
			result_ff <= nxt_result;
		end
	end

	// ------------------------------------------------------------
	// readout
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 14; gi++) begin : g_rev
			assign rev_w[gi] = result_ff[13 - gi];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readout_ff <= '0;
		end else if (fmt_ff == FMT_ANALOG && !lock_active_ff) begin
			readout_ff <= rev_w;
		end else begin
			readout_ff <= '0;
		end
	end

	// ------------------------------------------------------------
	// multiplexed halves
	// ------------------------------------------------------------
	assign is_mux_w   = (fmt_ff == FMT_MUX_CONT) || (fmt_ff == FMT_MUX_TRIG);
	assign mux_zero_w = (mux_tmr_ff == 32'h0000_0000);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mux_tmr_ff  <= '0;
			mux_half_ff <= 1'b0;
			mux_snap_ff <= '0;
		end else if (!is_mux_w) begin
			// a full lower slot comes first when the continuous mux format is entered from a non-multiplexed format
			mux_tmr_ff  <= SLOT_LAST;
			mux_half_ff <= 1'b0;
			mux_snap_ff <= result_ff;
		end else if (fmt_ff == FMT_MUX_CONT) begin
			// snapshot at the lower half keeps both halves one sample
			if (mux_zero_w) begin
				mux_tmr_ff  <= SLOT_LAST;
				mux_half_ff <= !mux_half_ff;
				if (mux_half_ff) begin
					mux_snap_ff <= result_ff;
				end
			end else begin
				mux_tmr_ff <= mux_tmr_ff - 32'h0000_0001;
			end
		end else begin
			mux_half_ff <= load_sync2_ff;
			if (mux_zero_w) begin
				mux_tmr_ff  <= REFR_LAST;
				mux_snap_ff <= result_ff;
			end else begin
				mux_tmr_ff <= mux_tmr_ff - 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------
	// pulse-width generator
	// ------------------------------------------------------------
	assign is_pwm_w = (fmt_ff == FMT_PWM) || (fmt_ff == FMT_PWM_INV);
	assign period_start_w = (pwm_tick_ff == 32'h0000_0000)
		&& (pwm_cnt_ff == 11'h000);

	always_comb begin
		nxt_duty = duty_ff;
		if (period_start_w) begin
			nxt_duty = (fmt_ff == FMT_PWM_INV) ? ~result_ff[13:3]
				: result_ff[13:3];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwm_tick_ff <= '0;
			pwm_cnt_ff  <= '0;
		end else if (pwm_tick_ff == TICK_LAST) begin
			pwm_tick_ff <= '0;
			pwm_cnt_ff  <= pwm_cnt_ff + 11'h001;
		end else begin
			pwm_tick_ff <= pwm_tick_ff + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			duty_ff    <= '0;
			pwm_out_ff <= 1'b0;
		end else begin
			duty_ff    <= nxt_duty;
			pwm_out_ff <= is_pwm_w && (pwm_cnt_ff < nxt_duty);
		end
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dac_code_ff <= '0;
			dac_en_ff   <= 1'b0;
			pwm_oe_n_ff <= 1'b1;
		end else begin
			dac_en_ff   <= !is_pwm_w;
			pwm_oe_n_ff <= !is_pwm_w;
			if (is_mux_w) begin
				// 128 steps per half, 39 mV each
				dac_code_ff <= {mux_half_ff ? mux_snap_ff[13:7]
					: mux_snap_ff[6:0], 5'h00};
			end else if (is_pwm_w) begin
				dac_code_ff <= '0;
			end else begin
				dac_code_ff <= result_ff[13:2];
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	clamp_window_a: assert property (@(posedge clk) disable iff (!rst_n)
		v1_ff && clamp_lo_w <= clamp_hi_w && $stable(nv_cfg) |=>
		result_ff >= $past(clamp_lo_w) && result_ff <= $past(clamp_hi_w))
		else $error("result outside clamp window");
	readout_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		fmt_ff != FMT_ANALOG |=> readout_ff == 14'h0000)
		else $error("readout not zero outside analog format");
	readout_rev_a: assert property (@(posedge clk) disable iff (!rst_n)
		fmt_ff == FMT_ANALOG && !lock_active_ff |=>
		readout_ff[0] == $past(result_ff[13])
		&& readout_ff[13] == $past(result_ff[0]))
		else $error("readout not bit reversed");
	duty_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!period_start_w |=> duty_ff == $past(duty_ff))
		else $error("duty changed inside a period");
	duty_invert_a: assert property (@(posedge clk) disable iff (!rst_n)
		period_start_w && fmt_ff == FMT_PWM_INV |=>
		duty_ff == ~$past(result_ff[13:3]))
		else $error("inverted duty not complemented");
	mux_lower_a: assert property (@(posedge clk) disable iff (!rst_n)
		is_mux_w && !mux_half_ff |=>
		dac_code_ff == {$past(mux_snap_ff[6:0]), 5'h00})
		else $error("lower half not on output");
	trig_select_a: assert property (@(posedge clk) disable iff (!rst_n)
		fmt_ff == FMT_MUX_TRIG ##1 fmt_ff == FMT_MUX_TRIG |->
		mux_half_ff == $past(load_sync2_ff))
		else $error("half does not follow load");
	cont_alternate_a: assert property (@(posedge clk) disable iff (!rst_n)
		fmt_ff == FMT_MUX_CONT && mux_zero_w ##1 fmt_ff == FMT_MUX_CONT
		|-> mux_half_ff != $past(mux_half_ff))
		else $error("continuous mux did not alternate");
	pwm_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		!is_pwm_w |=> !pwm_out_ff && pwm_oe_n_ff)
		else $error("pwm active outside pwm format");
	lock_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
		lock_seen_ff |=> $stable(lock_active_ff))
		else $error("lock changed after capture");

endmodule

/* tb/hdo_ecu_model.sv */
// Purpose: engine control unit model sampling the sensor output pin
// Assumes: the ecu load pulls the pin up or down
// Notes:   pwm times are counted in core clock cycles
module hdo_ecu_model (
	// clock
	input  wire logic        clk,
	// sensor pin
	input  wire logic        pwm_out,
	input  wire logic        pwm_oe_n,
	// load direction
	input  wire logic        pull_up,
	output logic             load_sense,
	// measurements
	output logic [15:0]      high_cyc,
	output logic [15:0]      period_cyc
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        pin;
	logic        prev_ff;
	logic [15:0] since_ff;

	// the load resistor decides which half the sensor sends
	assign load_sense = pull_up;
	// an undriven pin reads as the pull level, never the last pwm level
	assign pin = pwm_oe_n ? pull_up : pwm_out;

	// duty taken at the falling edge, period between rising edges
	always_ff @(posedge clk) begin
		prev_ff <= pin;
		if (pin && !prev_ff) begin
			period_cyc <= since_ff;
			since_ff   <= 16'h0001;
		end else begin
			since_ff <= since_ff + 16'h0001;
		end
		if (!pin && prev_ff) begin
			high_cyc <= since_ff;
		end
	end
endmodule

/* tb/tb_hall_dsp_output_conditioning.sv */
// Purpose: self-checking bench of the output conditioning block
// Assumes: pwm period shortened to 4096 cycles, mux slot 8, refresh 16
// Notes:   expected results are field*gain/2048 + offset*16, saturated,
//          then clamped at 32 result lsb per clamp step
module tb_hall_dsp_output_conditioning
	import hdo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk;
	logic              rst_n;
	hdo_nvcfg_type     cfg;
	logic [13:0]       field;
	logic              vld;
	logic              pull_up;
	logic              load_sense;
	hdo_conv_ctrl_type conv;
	logic [13:0]       readout;
	logic              prog_en;
	logic [11:0]       dac;
	logic              dac_en;
	logic              pwm;
	logic              pwm_oe_n;
	logic [15:0]       high_cyc;
	logic [15:0]       period_cyc;
	logic [11:0]       saw;
	int                fails;
	int                checks;
	int                cycles;

	// gain, offset, clamp cases and their clamped results
	// the last case tops out at offset plus one supply
	logic [13:0] c_f [9] = '{14'h03e8, 14'h03e8, 14'h0bb8, 14'h2000,
		14'h0064, 14'h1388, 14'h0064, 14'h1fff, 14'h1fff};
	logic [13:0] c_g [9] = '{14'h1000, 14'h3800, 14'h0800, 14'h0800,
		14'h0800, 14'h0800, 14'h0800, 14'h1000, 14'h1800};
	logic [10:0] c_o [9] = '{11'h100, 11'h200, 11'h7c0, 11'h000,
		11'h000, 11'h000, 11'h000, 11'h100, 11'h7c0};
	logic [7:0]  c_lo [9] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h0a, 8'h00, 8'hff, 8'h00, 8'h00};
	logic [8:0]  c_hi [9] = '{9'h1ff, 9'h1ff, 9'h1ff, 9'h1ff,
		9'h1ff, 9'h064, 9'h064, 9'h1ff, 9'h1ff};
	logic [13:0] c_r [9] = '{14'h17d0, 14'h1c18, 14'h07b8, 14'h0000,
		14'h0140, 14'h0c80, 14'h0c80, 14'h3fe0, 14'h3bff};
	logic [2:0]  rc [6] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [1:0]  fc [4] = '{2'h0, 2'h2, 2'h3, 2'h1};

	hdo_core #(
		.PWM_PERIOD_CYC  (4096),
		.MUX_SLOT_CYC    (8),
		.TRIG_REFRESH_CYC(16)
	) dut (
		.clk(clk), .rst_n(rst_n), .nv_cfg(cfg),
		.field_sample(field), .sample_valid(vld),
		.load_sense_in(load_sense), .conv_ctrl_ff(conv),
		.readout_ff(readout), .prog_enable_ff(prog_en),
		.dac_code_ff(dac), .dac_en_ff(dac_en),
		.pwm_out_ff(pwm), .pwm_oe_n_ff(pwm_oe_n)
	);

	hdo_ecu_model ecu (
		.clk(clk), .pwm_out(pwm), .pwm_oe_n(pwm_oe_n),
		.pull_up(pull_up), .load_sense(load_sense),
		.high_cyc(high_cyc), .period_cyc(period_cyc)
	);

	// ---------
	// helpers
	// ---------
	always #20 clk = ~clk;

	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// a hang is cut short well past the longest pwm test
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic path(input logic [2:0] fmt, input logic [13:0] g,
		input logic [10:0] o, input logic [7:0] lo, input logic [8:0] hi);
		@(posedge clk);
		cfg.signal_path_config <= {2'h0, fmt, 5'h00};
		cfg.gain               <= g;
		cfg.offset             <= o;
		cfg.clamp_low          <= lo;
		cfg.clamp_high         <= hi;
		tick(3);
	endtask

	task automatic sample(input logic [13:0] f);
		@(posedge clk);
		field <= f;
		vld   <= 1'b1;
		@(posedge clk);
		vld <= 1'b0;
		tick(5);
	endtask

	task automatic next_dac();
		logic [11:0] v;
		v = dac;
		for (int i = 0; i < 30 && dac === v; i++) tick(1);
	endtask

	function automatic logic [13:0] rev(input logic [13:0] v);
		return {<<{v}};
	endfunction

	// ---------
	// sequence
	// ---------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		cfg = '0;
		cfg.lock = 1'b1;
		field = 14'h0000;
		vld = 1'b0;
		pull_up = 1'b0;
		fails = 0;
		checks = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		tick(3);
		check("prog_en", prog_en, 0);
		path(3'h0, 14'h0800, 11'h100, 8'h00, 9'h1ff);
		sample(14'h0000);
		check("readout", readout, 0);
		// lock stays until the next power cycle even when cleared
		@(posedge clk);
		cfg.lock <= 1'b0;
		tick(3);
		check("prog_en", prog_en, 0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		tick(3);
		check("prog_en", prog_en, 1);
		for (int i = 0; i < 9; i++) begin
			path(3'h0, c_g[i], c_o[i], c_lo[i], c_hi[i]);
			sample(c_f[i]);
			check("readout", readout, rev(c_r[i]));
			check("dac", dac, c_r[i][13:2]);
		end
		check("dac_en", {dac_en, pwm_oe_n}, 2'h3);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			cfg.signal_path_config <= {rc[i][2], 4'h0, fc[i % 4],
				rc[i][1:0], 1'b0};
			cfg.tc_group <= 2'(i + 2);
			cfg.linear_temp_coeff <= 5'(i * 5);
			cfg.quadratic_temp_coeff <= 3'(i);
			tick(3);
			check("range", conv.range, i);
			check("filter", conv.filter, i % 4);
			check("group", conv.temp_coeff_group,
				i == 0 ? 1 : (i + 2) % 4);
			check("coeff", {conv.linear_temp_coeff,
				conv.quadratic_temp_coeff}, {5'(i * 5), 3'(i)});
		end
		// triggered halves follow the load direction
		path(3'h3, 14'h0800, 11'h000, 8'h00, 9'h1ff);
		sample(14'h1234);
		@(posedge clk);
		pull_up <= 1'b1;
		tick(40);
		check("mux_up", dac, {7'h24, 5'h00});
		check("readout", readout, 0);
		@(posedge clk);
		pull_up <= 1'b0;
		tick(40);
		check("mux_lo", dac, {7'h34, 5'h00});
		path(3'h1, 14'h0800, 11'h000, 8'h00, 9'h1ff);
		for (int i = 0; i < 4 && dac !== {7'h34, 5'h00}; i++) next_dac();
		check("cont_lo", dac, {7'h34, 5'h00});
		next_dac();
		check("cont_up", dac, {7'h24, 5'h00});
		next_dac();
		check("cont_lo", dac, {7'h34, 5'h00});
		// sawtooth ignores the field and steps per sample
		path(3'h2, 14'h0800, 11'h000, 8'h00, 9'h1ff);
		sample(14'h0000);
		saw = dac;
		sample(14'h0000);
		check("saw", 12'(dac - saw), 4);
		path(3'h6, 14'h0800, 11'h200, 8'h00, 9'h1ff);
		sample(14'h0000);
		tick(8292);
		check("pwm_high", high_cyc, 2048);
		check("pwm_period", period_cyc, 4096);
		check("pwm_pin", {pwm_oe_n, dac_en}, 2'h0);
		// a new sample in the high phase must wait for the next period
		for (int i = 0; i < 5000 && pwm !== 1'b1; i++) tick(1);
		sample(14'h3000);
		for (int i = 0; i < 5000 && pwm === 1'b1; i++) tick(1);
		tick(2);
		check("pwm_hold", high_cyc, 2048);
		tick(4200);
		check("pwm_new", high_cyc, 1024);
		path(3'h7, 14'h0800, 11'h200, 8'h00, 9'h1ff);
		tick(8292);
		check("pwm_inv", high_cyc, 3070);
		complete_run();
	end
endmodule
